/* File: logic/ctu_pkg.sv */
`default_nettype none
package ctu_pkg;
	typedef enum logic [2:0] {
		CTU_M_TIMER8, CTU_M_PDO8, CTU_M_PWM8, CTU_M_RSVD,
		CTU_M_TIMER16, CTU_M_WARMUP, CTU_M_PWM16, CTU_M_PPG16
	} ctu_mode_e;
	typedef struct packed {
		logic ff_init;
		logic [2:0] clk_sel;
		logic run;
		logic [2:0] mode;
	} ctu_ctrl_s;
	typedef struct packed {
		logic div2;
		logic div8;
		logic div32;
		logic div128;
		logic div2048;
		logic low;
		logic low_div8;
	} ctu_ticks_s;
endpackage
`default_nettype wire

/* File: logic/ctu_regs.svh */
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH
`define CTU_IDX_CTRL 8'h17
`define CTU_IDX_PERIOD 8'h19
`define CTU_IDX_PWIDTH 8'h1B
`define CTU_IDX_IRQ_STAT 8'h20
`define CTU_IDX_IRQ_MASK 8'h21
`define CTU_IDX_TAP 8'h22
`define CTU_RST_CTRL 8'h00
`define CTU_RST_PERIOD 8'hFF
`define CTU_RST_PWIDTH 8'hFF
`define CTU_FF_BIT 7
`define CTU_CK_MSB 6
`define CTU_CK_LSB 4
`define CTU_RUN_BIT 3
`define CTU_MODE_MSB 2
`define CTU_MODE_LSB 0
`endif

/* File: logic/ctu_upper_timer.sv */
// Function
// (R1) One control register plus 8-bit period and pulse-width compare registers.
// (R2) Software leaves period compare alone while the timer runs.
// (R3) Pulse-width compare rewritable while running only in PWM modes.
// (R4) Flip-flop control bit written 0 clears, 1 sets the output flip-flop.
// (R5) Clock select picks count source from prescaler taps or low clock.
// (R6) Run bit 0 stops and clears counter; 1 starts counting.
// (R7) Mode 101 warm-up, 110 16-bit PWM, 111 16-bit pulse generation.
// (R8) Software keeps mode, clock and flip-flop fields while running or stopping.
// (R9) Start write may load new mode, clock and flip-flop values.
// (R10) Modes 1xx count lower timer overflow, ignore own clock select.
// (R11) Software sets lower mode 011 for any cascaded mode.
// (R12) Lower clock select drives pair; upper run and flip-flop govern pair.
// (R13) Undivided high clock only used in 8-bit PWM mode; code selects it on clock select 6 in any mode 0xx outside low-speed run mode.
// (R14) High-speed modes restrict usable sources per operating mode; code restricts only in low-speed run mode, to selects 0 and 4.
// (R15) Control layout: ff bit 7, clock 6:4, run 3, mode 2:0.
// (R16) Mode 000 timer, 001 divider, 010 PWM, 011 reserved, 100 16-bit.
//
// Our own choice: register access over APB.
`include "ctu_regs.svh"
`default_nettype none
module ctu_upper_timer
	import ctu_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ctu_ticks_s ticks,
	input wire logic low_speed_run_mode,
	input wire logic lower_overflow,
	output logic upper_run,
	output logic [2:0] upper_mode_select,
	output logic upper_count_tick,
	output logic upper_output_flipflop,
	output logic [7:0] upper_period_compare,
	output logic [7:0] upper_pulse_width_compare,
	output logic irq
);
	ctu_ctrl_s ctrl_r, ctrl_nxt;
	logic [7:0] period_r, period_nxt, pwidth_r, pwidth_nxt;
	logic ff_r, ff_nxt;
	logic tick_r, tick_nxt;
	logic [2:0] stat_r, stat_nxt;
	logic [2:0] mask_r, mask_nxt;
	logic tap_r, tap_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic slverr_r, slverr_nxt;
	logic wr, rd, hit, src;
	logic [9:0] idx;
	logic wr_ctrl, wr_period, wr_pwidth, pwm_mode;
	ctu_ctrl_s wctl;

	assign pready = 1'b1;
	assign pslverr = psel & penable & slverr_r;
	assign prdata = rdata_r;
	assign idx = paddr[11:2];
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign wctl = ctu_ctrl_s'(pwdata[7:0]); // R15
	assign wr_ctrl = wr && idx == 10'(`CTU_IDX_CTRL);
	assign wr_period = wr && idx == 10'(`CTU_IDX_PERIOD);
	assign wr_pwidth = wr && idx == 10'(`CTU_IDX_PWIDTH);
	assign pwm_mode = ctrl_r.mode == CTU_M_PWM8 || ctrl_r.mode == CTU_M_PWM16;

	// Count source selection
	always_comb begin
		if (ctrl_r.mode[2]) begin
			src = lower_overflow; // R10 R12
		end else if (low_speed_run_mode) begin
			src = ctrl_r.clk_sel == 3'h0 ? ticks.low_div8 :
				ctrl_r.clk_sel == 3'h4 ? ticks.low : 1'b0; // R5
		end else begin
			case (ctrl_r.clk_sel) // R5
				3'h0: src = tap_r ? ticks.low_div8 : ticks.div2048;
				3'h1: src = ticks.div128;
				3'h2: src = ticks.div32;
				3'h3: src = ticks.div8;
				3'h4: src = ticks.low;
				3'h5: src = ticks.div2;
				3'h6: src = 1'b1;
				default: src = 1'b0;
			endcase
		end
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		period_nxt = period_r;
		pwidth_nxt = pwidth_r;
		ff_nxt = ff_r;
		tap_nxt = tap_r;
		mask_nxt = mask_r;
		tick_nxt = ctrl_r.run & src; // R6
		if (wr_ctrl) begin
			if (!ctrl_r.run) begin
				ctrl_nxt = wctl; // R9
				ff_nxt = wctl.ff_init; // R4
			end else begin
				ctrl_nxt.run = wctl.run; // R8
			end
			if (!wctl.run) begin
				tick_nxt = 1'b0; // R6
			end
		end
		if (wr_period) begin
			period_nxt = pwdata[7:0]; // R1 R2
		end
		if (wr_pwidth) begin
			pwidth_nxt = pwdata[7:0]; // R1 R3
		end
		if (wr && idx == 10'(`CTU_IDX_IRQ_MASK)) begin
			mask_nxt = pwdata[2:0];
		end
		if (wr && idx == 10'(`CTU_IDX_TAP)) begin
			tap_nxt = pwdata[0];
		end
	end

	// Sticky events: start, stop, running pwidth update in PWM modes; read clears, set wins
	always_comb begin
		stat_nxt = stat_r;
		if (rd && idx == 10'(`CTU_IDX_IRQ_STAT)) begin
			stat_nxt = 3'h0;
		end
		if (wr_ctrl && !ctrl_r.run && wctl.run) begin
			stat_nxt[0] = 1'b1;
		end
		if (wr_ctrl && ctrl_r.run && !wctl.run) begin
			stat_nxt[1] = 1'b1;
		end
		if (wr_pwidth && ctrl_r.run && pwm_mode) begin
			stat_nxt[2] = 1'b1;
		end
	end

	always_comb begin
		rdata_nxt = rdata_r;
		slverr_nxt = 1'b0;
		hit = 1'b1;
		if (psel && !penable) begin
			rdata_nxt = 32'h0;
			if (idx == 10'(`CTU_IDX_CTRL)) begin
				rdata_nxt[7:0] = ctrl_r;
			end else if (idx == 10'(`CTU_IDX_PERIOD)) begin
				rdata_nxt[7:0] = period_r;
			end else if (idx == 10'(`CTU_IDX_PWIDTH)) begin
				rdata_nxt[7:0] = pwidth_r;
			end else if (idx == 10'(`CTU_IDX_IRQ_STAT)) begin
				rdata_nxt[2:0] = stat_r;
			end else if (idx == 10'(`CTU_IDX_IRQ_MASK)) begin
				rdata_nxt[2:0] = mask_r;
			end else if (idx == 10'(`CTU_IDX_TAP)) begin
				rdata_nxt[0] = tap_r;
			end else begin
				hit = 1'b0;
			end
			slverr_nxt = ~hit;
		end else begin
			slverr_nxt = slverr_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_r <= ctu_ctrl_s'(`CTU_RST_CTRL);
			period_r <= `CTU_RST_PERIOD;
			pwidth_r <= `CTU_RST_PWIDTH;
			ff_r <= 1'b0;
			tick_r <= 1'b0;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
			tap_r <= 1'b0;
			rdata_r <= 32'h0;
			slverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			period_r <= period_nxt;
			pwidth_r <= pwidth_nxt;
			ff_r <= ff_nxt;
			tick_r <= tick_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			tap_r <= tap_nxt;
			rdata_r <= rdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	assign upper_run = ctrl_r.run;
	assign upper_mode_select = ctrl_r.mode; // R7 R16
	assign upper_count_tick = tick_r;
	assign upper_output_flipflop = ff_r;
	assign upper_period_compare = period_r;
	assign upper_pulse_width_compare = pwidth_r;
	assign irq = |(stat_r & mask_r);

	a_ff_load: assert property (@(posedge core_clk) disable iff (reset)
		wr_ctrl && !ctrl_r.run |=> ff_r == $past(pwdata[`CTU_FF_BIT])) // R4
		else $error("flip-flop not loaded");
	a_stop_tick: assert property (@(posedge core_clk) disable iff (reset)
		!ctrl_r.run |=> !tick_r) // R6
		else $error("tick while stopped");
	a_ctrl_hold: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.run |=> ctrl_r.mode == $past(ctrl_r.mode)) // R8
		else $error("mode changed while running");
	a_casc_src: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.run && ctrl_r.mode[2] && !wr_ctrl |=> tick_r == $past(lower_overflow)) // R10
		else $error("cascade tick wrong");
	a_fc_src: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.run && ctrl_r.mode == CTU_M_PWM8 && ctrl_r.clk_sel == 3'h6
		&& !low_speed_run_mode && !wr_ctrl |=> tick_r) // R5
		else $error("fc tick missing");
	a_period_wr: assert property (@(posedge core_clk) disable iff (reset)
		wr_period |=> period_r == $past(pwdata[7:0])) // R1
		else $error("period not written");
	a_pw_wr: assert property (@(posedge core_clk) disable iff (reset)
		wr_pwidth |=> pwidth_r == $past(pwdata[7:0])) // R1
		else $error("pwidth not written");
	a_irq_lvl: assert property (@(posedge core_clk) disable iff (reset)
		irq |-> (stat_r & mask_r) != 3'h0)
		else $error("irq without cause");
	a_irq_set: assert property (@(posedge core_clk) disable iff (reset)
		(stat_r & mask_r) != 3'h0 |-> irq)
		else $error("irq missing");

	// Start write takes new fields and flags the start
	sequence s_start_wr;
		wr_ctrl && !ctrl_r.run && wctl.run;
	endsequence
	sequence s_started;
		ctrl_r.run && stat_r[0] && ctrl_r == $past(wctl);
	endsequence
	// Own clock select in use, no control write pending
	sequence s_own_src(logic [2:0] s);
		ctrl_r.run && !ctrl_r.mode[2] && !low_speed_run_mode && ctrl_r.clk_sel == s && !wr_ctrl;
	endsequence
	sequence s_slow_src(logic [2:0] s);
		ctrl_r.run && !ctrl_r.mode[2] && low_speed_run_mode && ctrl_r.clk_sel == s && !wr_ctrl;
	endsequence

	a_start_seq: assert property (@(posedge core_clk) disable iff (reset)
		s_start_wr |=> s_started) // R9
		else $error("start write not taken");
	a_stop_flag: assert property (@(posedge core_clk) disable iff (reset)
		wr_ctrl && ctrl_r.run && !wctl.run |=> !ctrl_r.run && stat_r[1]) // R6
		else $error("stop not taken");
	a_stop_kill: assert property (@(posedge core_clk) disable iff (reset)
		wr_ctrl && !wctl.run |=> !tick_r) // R6
		else $error("tick after stop write");
	a_pw_flag: assert property (@(posedge core_clk) disable iff (reset)
		wr_pwidth && ctrl_r.run && pwm_mode |=> stat_r[2]) // R3
		else $error("pwidth flag missing");
	a_stat_clear: assert property (@(posedge core_clk) disable iff (reset)
		rd && idx == 10'(`CTU_IDX_IRQ_STAT) |=> stat_r == 3'h0)
		else $error("status not cleared");
	a_ff_hold: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.run |=> ff_r == $past(ff_r)) // R8
		else $error("flip-flop changed while running");
	a_clk_hold: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.run |=> ctrl_r.clk_sel == $past(ctrl_r.clk_sel)) // R8
		else $error("clock select changed while running");
	a_tap_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h0) |=> tick_r == $past(tap_r ? ticks.low_div8 : ticks.div2048)) // R5
		else $error("tap source wrong");
	a_div128_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h1) |=> tick_r == $past(ticks.div128)) // R5
		else $error("div128 source wrong");
	a_div32_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h2) |=> tick_r == $past(ticks.div32)) // R5
		else $error("div32 source wrong");
	a_div8_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h3) |=> tick_r == $past(ticks.div8)) // R5
		else $error("div8 source wrong");
	a_low_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h4) |=> tick_r == $past(ticks.low)) // R5
		else $error("low source wrong");
	a_div2_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h5) |=> tick_r == $past(ticks.div2)) // R5
		else $error("div2 source wrong");
	a_none_src: assert property (@(posedge core_clk) disable iff (reset)
		s_own_src(3'h7) |=> !tick_r) // R5
		else $error("tick on unused select");
	a_slow_tap: assert property (@(posedge core_clk) disable iff (reset)
		s_slow_src(3'h0) |=> tick_r == $past(ticks.low_div8)) // R5
		else $error("slow tap source wrong");
	a_slow_bad: assert property (@(posedge core_clk) disable iff (reset)
		s_slow_src(3'h6) |=> !tick_r) // R5
		else $error("invalid slow source ticked");
	a_ctrl_rd: assert property (@(posedge core_clk) disable iff (reset)
		psel && !penable && idx == 10'(`CTU_IDX_CTRL) |=> prdata == {24'h0, $past(ctrl_r)}) // R15
		else $error("control readback wrong");
	a_unmapped: assert property (@(posedge core_clk) disable iff (reset)
		psel && !penable && !(idx inside {10'(`CTU_IDX_CTRL), 10'(`CTU_IDX_PERIOD),
		10'(`CTU_IDX_PWIDTH), 10'(`CTU_IDX_IRQ_STAT), 10'(`CTU_IDX_IRQ_MASK),
		10'(`CTU_IDX_TAP)}) |=> slverr_r)
		else $error("unmapped access not flagged");
	a_rst_vals: assert property (@(posedge core_clk)
		$past(reset) |-> ctrl_r == ctu_ctrl_s'(`CTU_RST_CTRL) && period_r == `CTU_RST_PERIOD
		&& pwidth_r == `CTU_RST_PWIDTH && !ff_r && !tick_r) // R1
		else $error("reset values wrong");
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
module testbench;
	import ctu_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, reset, psel, penable, pwrite, lower_overflow, low_speed_run_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [32:0] exp_q[$];
	logic pready, pslverr, upper_run, upper_count_tick, upper_output_flipflop, irq;
	logic [2:0] upper_mode_select;
	logic [7:0] upper_period_compare, upper_pulse_width_compare, v;
	ctu_ticks_s ticks;
	int n_fail = 0;
	int tests_run = 0;
	ctu_upper_timer i_ctu_upper_timer (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ticks, .low_speed_run_mode, .lower_overflow,
		.upper_run, .upper_mode_select, .upper_count_tick, .upper_output_flipflop,
		.upper_period_compare, .upper_pulse_width_compare, .irq);
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic summarize;
		$display("fails %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask
	// Read results checked as they appear, in order
	always @(posedge core_clk) begin
		if (psel && penable && !pwrite && pready)
			chk({pslverr, prdata}, exp_q.pop_front());
	end
	always @(posedge core_clk) ticks <= ctu_ticks_s'($urandom);
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, lower_overflow, low_speed_run_mode} = '0;
		ticks = '0;
		reset = 1'h1;
		void'($urandom(32'h99BDDF2E));
		repeat (3) @(posedge core_clk);
		reset <= 1'h0;
		rd(12'h05C, 33'h0);
		rd(12'h064, 33'hFF);
		rd(12'h06C, 33'hFF);
		v = 8'($urandom);
		apb(1'h1, 12'h064, {24'h0, v});
		rd(12'h064, {25'h0, v});
		chk(upper_period_compare, {25'h0, v});
		apb(1'h1, 12'h084, 32'h1);
		apb(1'h1, 12'h05C, 32'hEA);
		@(negedge core_clk);
		chk(upper_output_flipflop, 1);
		chk(upper_run, 1);
		chk(irq, 1);
		@(negedge core_clk);
		chk(upper_count_tick, 1);
		rd(12'h080, 33'h1);
		apb(1'h1, 12'h06C, {24'h0, ~v});
		rd(12'h06C, {25'h0, ~v});
		chk(upper_pulse_width_compare, {25'h0, ~v});
		rd(12'h080, 33'h4);
		apb(1'h1, 12'h05C, 32'h0D);
		rd(12'h05C, 33'hEA);
		apb(1'h1, 12'h05C, 32'h62);
		@(negedge core_clk);
		chk(upper_run, 0);
		chk(upper_output_flipflop, 1);
		chk(irq, 0);
		@(negedge core_clk);
		chk(upper_count_tick, 0);
		rd(12'h05C, 33'hE2);
		apb(1'h1, 12'h05C, 32'h0D);
		@(negedge core_clk);
		chk(upper_output_flipflop, 0);
		chk(upper_mode_select, CTU_M_WARMUP);
		@(posedge core_clk);
		lower_overflow <= 1'h1;
		@(posedge core_clk);
		lower_overflow <= 1'h0;
		@(negedge core_clk);
		chk(upper_count_tick, 1);
		repeat (2) @(negedge core_clk);
		chk(upper_count_tick, 0);
		rd(12'h090, {1'h1, 32'h0});
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule
`default_nettype wire
